/* File: lbm_regs.sv */
// Register bank for long bandwidth counters, their snapshots, the monitor
// select and the error status/control pair, one copy per security state.
// Assumes a single-beat 64-bit register port, pre-filtered traffic events and
// capability straps that are static while the bank is in use.
`timescale 1ns/10ps

// Summary of operation
// R1: Secure and Non-secure counters, snapshots and error controls are separate copies.
// R2: Each copy is reached only through its own security page.
// R3: With instance select, counter access uses instance selector plus monitor index.
// R4: Without instance select, counter access uses only the monitor index.
// R5: With instance select, snapshot access uses the selected instance and monitor.
// R6: Snapshot exists only with all four capabilities; otherwise reads zero, ignores writes.
// R7: Snapshot is 64 bits with not-ready in bit 63.
// R8: Short form holds 44-bit count; bits 62 to 44 read zero.
// R9: Long form holds 63-bit count directly below not-ready.
// R10: Not-ready zero means accurate count; one means possibly invalid.
// R11: Count is filtered bytes transferred since the counter was last loaded.
// R12: Error control is 32 bits; bit 0 enables interrupts; rest reads zero.
// R13: Each error control governs only its own security state.
// R14: Each error status records only its own security state's errors.
// R15: Without possible errors, status and control read zero and ignore writes.
// R16: Error status is 64 bits with extended option, else 32 bits.
// R17: Software should clear code and overwritten flag after reading an error.
// R18: A state's error raises its interrupt only when its enable is one.
// R19: Overwritten flag at bit 31, four-bit code at 27:24, zero means none.
// R20: A second error sets overwritten and keeps newest; never flag with zero code.
// R21: A capture copies live value and not-ready together into the snapshot.
// R22: Reads follow the current selection; reserved bits always read zero.
module lbm_regs
  import lbm_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   resetn,
  input  lbm_caps_s   caps,
  input  lbm_req_s    req,
  output lbm_rsp_s    rsp,
  input  lbm_traffic_s traffic,
  input  wire logic   captureValid,
  input  wire logic   captureNonSecure,
  input  wire logic   counterNotReady,
  input  lbm_err_s    err,
  output logic        errIrqSecure,
  output logic        errIrqNonSecure
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    lbm_sel_s [1:0]                 monSel;
    logic [1:0]                     irqEnable;
    logic [1:0][63:0]               errStatus;
    logic [LBM_NUM_CTR-1:0][63:0]   snapshot;
    lbm_rsp_s                       rsp;
  } lbm_state_s;

  lbm_state_s st;
  lbm_state_s next_st;

  lbm_ctr_s ctrState [LBM_NUM_CTR];

  logic                 page;
  logic [LBM_IDX_W-1:0] selIdx;
  logic [LBM_IDX_W:0]   ctrIdx;
  logic                 longPresent;
  logic                 snapPresent;
  logic                 wrLong;
  logic [LBM_IDX_W:0]   trafficIdx;
  logic [63:0]          esrMask;
  logic [63:0]          liveWord;

  // ---------------------------------------------------------------------------
  // Selection and capability decode
  // ---------------------------------------------------------------------------
  // Page 0 is the Secure frame, page 1 the Non-secure frame; each frame only
  // ever sees its own selector and its own copies.
  assign page = req.nonSecure; // R2

  always_comb begin
    if (caps.hasInstanceSelect) begin
      selIdx = {st.monSel[page].resource_instance_selector, st.monSel[page].mon}; // R3 R5
    end else begin
      selIdx = {{LBM_RIS_W{1'b0}}, st.monSel[page].mon}; // R4
    end
  end

  assign ctrIdx      = {page, selIdx}; // R1
  assign longPresent = caps.hasMonitoring & caps.hasBwMonitor & caps.hasLong;
  assign snapPresent = longPresent & caps.hasCapture; // R6
  assign wrLong      = req.valid & req.write & (req.addr == LBM_OFS_LONG_CTR) & longPresent;
  assign esrMask     = caps.hasExtendedStatus ? LBM_ESR_MASK_EXTD : LBM_ESR_MASK_NARROW; // R16

  // Traffic without instance selection always lands on instance zero.
  always_comb begin
    if (caps.hasInstanceSelect) begin
      trafficIdx = {traffic.nonSecure, traffic.resource_instance_selector, traffic.mon};
    end else begin
      trafficIdx = {traffic.nonSecure, {LBM_RIS_W{1'b0}}, traffic.mon};
    end
  end

  // ---------------------------------------------------------------------------
  // Live counters
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < LBM_NUM_CTR; g++) begin : gCtr
    lbm_long_counter uCtr (
      .clk         (clk),
      .resetn      (resetn),
      .longWidth   (caps.longWidth), // R8 R9
      .wrEn        (wrLong && (ctrIdx == (LBM_IDX_W+1)'(g))), // R3 R4
      .wrData      (req.wdata),
      .addEn       (traffic.valid && (trafficIdx == (LBM_IDX_W+1)'(g)) && longPresent), // R11
      .addBytes    (traffic.bytes),
      .setNotReady (counterNotReady),
      .state       (ctrState[g])
    );
  end

  assign liveWord = ctrState[ctrIdx];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp.valid = 1'b0;
    next_st.rsp.rdata = 64'h0;

    // Read path: the answer reflects the selector as it stood when the request
    // was taken, and every field not listed stays zero.
    if (req.valid && !req.write) begin
      next_st.rsp.valid = 1'b1;
      unique case (req.addr)
        LBM_OFS_ERR_CTRL: begin
          if (caps.errorsPossible) begin
            next_st.rsp.rdata = {63'h0, st.irqEnable[page]}; // R12 R15
          end
        end
        LBM_OFS_ERR_STATUS: begin
          if (caps.errorsPossible) begin
            next_st.rsp.rdata = st.errStatus[page] & esrMask; // R14 R15 R16
          end
        end
        LBM_OFS_MON_SELECT: begin
          next_st.rsp.rdata = 64'h0;
          next_st.rsp.rdata[LBM_SEL_MON_LSB +: LBM_MON_W] = st.monSel[page].mon;
          if (caps.hasInstanceSelect) begin
            next_st.rsp.rdata[LBM_SEL_RIS_LSB +: LBM_RIS_W] = st.monSel[page].resource_instance_selector;
          end
        end
        LBM_OFS_LONG_CTR: begin
          if (longPresent) begin
            next_st.rsp.rdata = liveWord; // R22
          end
        end
        LBM_OFS_LONG_SNAP: begin
          if (snapPresent) begin
            next_st.rsp.rdata = st.snapshot[ctrIdx]; // R5 R7 R22
          end
        end
        default: begin
          next_st.rsp.rdata = 64'h0;
        end
      endcase
    end

    // Write path.
    if (req.valid && req.write) begin
      unique case (req.addr)
        LBM_OFS_ERR_CTRL: begin
          if (caps.errorsPossible) begin
            next_st.irqEnable[page] = req.wdata[LBM_IRQ_EN_BIT]; // R12 R13 R15
          end
        end
        LBM_OFS_ERR_STATUS: begin
          if (caps.errorsPossible) begin
            next_st.errStatus[page] = req.wdata & esrMask; // R16 R17
          end
        end
        LBM_OFS_MON_SELECT: begin
          next_st.monSel[page].mon = req.wdata[LBM_SEL_MON_LSB +: LBM_MON_W];
          if (caps.hasInstanceSelect) begin
            next_st.monSel[page].resource_instance_selector = req.wdata[LBM_SEL_RIS_LSB +: LBM_RIS_W];
          end
        end
        LBM_OFS_LONG_SNAP: begin
          if (snapPresent) begin
            if (caps.longWidth) begin
              next_st.snapshot[ctrIdx] = req.wdata; // R9
            end else begin
              next_st.snapshot[ctrIdx] = req.wdata & LBM_SHORT_MASK; // R8
            end
          end
        end
        default: begin
          next_st.monSel = next_st.monSel;
        end
      endcase
    end

    // Capture: every counter of the chosen state is copied in one edge, value
    // and not-ready together, so software never sees a torn pair. A capture
    // in the same cycle as a software snapshot write wins over it.
    if (captureValid && snapPresent) begin
      for (int i = 0; i < LBM_PER_STATE; i++) begin
        next_st.snapshot[{captureNonSecure, i[LBM_IDX_W-1:0]}] =
          ctrState[{captureNonSecure, i[LBM_IDX_W-1:0]}]; // R21
      end
    end

    // Error capture: applied after the software write so that an error
    // arriving in the clearing cycle is kept. A zero code is not an error and
    // is dropped, so the flag can never rise with a zero code.
    if (err.valid && caps.errorsPossible && (err.code != 4'h0)) begin
      next_st.errStatus[err.nonSecure][LBM_ESR_OVR_BIT] =
        (next_st.errStatus[err.nonSecure][LBM_ESR_CODE_LSB +: 4] != 4'h0); // R20
      next_st.errStatus[err.nonSecure][LBM_ESR_CODE_LSB +: 4] = err.code; // R14 R19
      next_st.errStatus[err.nonSecure][LBM_ESR_PMG_LSB +: 8]  = err.pmg;
      next_st.errStatus[err.nonSecure][15:0]                  = err.partMon;
      next_st.errStatus[err.nonSecure][LBM_ESR_RIS_LSB +: 4]  = err.resource_instance_selector;
      next_st.errStatus[err.nonSecure] = next_st.errStatus[err.nonSecure] & esrMask;
      if (!caps.hasInstanceSelect) begin
        next_st.errStatus[err.nonSecure][LBM_ESR_RIS_LSB +: 4] = 4'h0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st.monSel    <= '0;
      st.irqEnable <= {LBM_RST_IRQEN, LBM_RST_IRQEN};
      st.errStatus <= {LBM_RST_VALUE, LBM_RST_VALUE};
      st.snapshot  <= '0;
      st.rsp       <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rsp = st.rsp;

  // The interrupt is a level that stays up until software clears the code or
  // drops the enable.
  assign errIrqSecure    = caps.errorsPossible & st.irqEnable[0]
                         & (st.errStatus[0][LBM_ESR_CODE_LSB +: 4] != 4'h0); // R18 R13
  assign errIrqNonSecure = caps.errorsPossible & st.irqEnable[1]
                         & (st.errStatus[1][LBM_ESR_CODE_LSB +: 4] != 4'h0); // R18 R13

endmodule // lbm_regs

/* File: lbm_pkg.sv */
// Constants, field layouts and carrier types for the long bandwidth monitor
// and error control register bank.
// Assumes one clock, a synchronous active-low reset and a 64-bit register port.
package lbm_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets within one feature page
  // ---------------------------------------------------------------------------
  localparam logic [11:0] LBM_OFS_ERR_CTRL   = 12'h0f0;
  localparam logic [11:0] LBM_OFS_ERR_STATUS = 12'h0f8;
  localparam logic [11:0] LBM_OFS_MON_SELECT = 12'h800;
  localparam logic [11:0] LBM_OFS_LONG_CTR   = 12'h880;
  localparam logic [11:0] LBM_OFS_LONG_SNAP  = 12'h890;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int LBM_MON_W     = 2;
  localparam int LBM_RIS_W     = 2;
  localparam int LBM_IDX_W     = LBM_MON_W + LBM_RIS_W;
  localparam int LBM_PER_STATE = 1 << LBM_IDX_W;
  localparam int LBM_NUM_CTR   = 2 * LBM_PER_STATE;
  localparam int LBM_BYTES_W   = 16;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LBM_NOT_READY_BIT_BIT      = 63;
  localparam int LBM_SHORT_MSB     = 43;
  localparam int LBM_IRQ_EN_BIT    = 0;
  localparam int LBM_SEL_MON_LSB   = 0;
  localparam int LBM_SEL_RIS_LSB   = 24;
  localparam int LBM_ESR_OVR_BIT   = 31;
  localparam int LBM_ESR_CODE_LSB  = 24;
  localparam int LBM_ESR_PMG_LSB   = 16;
  localparam int LBM_ESR_RIS_LSB   = 32;

  // Writable bits of the status record, narrow and extended forms.
  localparam logic [63:0] LBM_ESR_MASK_NARROW = 64'h0000_0000_8fff_ffff;
  localparam logic [63:0] LBM_ESR_MASK_EXTD   = 64'h0000_000f_8fff_ffff;
  localparam logic [63:0] LBM_SHORT_MASK      = 64'h8000_0fff_ffff_ffff;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [63:0] LBM_RST_VALUE = 64'h0000_0000_0000_0000;
  localparam logic        LBM_RST_IRQEN = 1'b0;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        nonSecure;
    logic        write;
    logic [11:0] addr;
    logic [63:0] wdata;
  } lbm_req_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] rdata;
  } lbm_rsp_s;

  typedef struct packed {
    logic                   valid;
    logic                   nonSecure;
    logic [LBM_RIS_W-1:0]   resource_instance_selector;
    logic [LBM_MON_W-1:0]   mon;
    logic [LBM_BYTES_W-1:0] bytes;
  } lbm_traffic_s;

  typedef struct packed {
    logic        valid;
    logic        nonSecure;
    logic [3:0]  code;
    logic [3:0]  resource_instance_selector;
    logic [7:0]  pmg;
    logic [15:0] partMon;
  } lbm_err_s;

  typedef struct packed {
    logic hasMonitoring;
    logic hasBwMonitor;
    logic hasCapture;
    logic hasLong;
    logic longWidth;
    logic hasInstanceSelect;
    logic hasExtendedStatus;
    logic errorsPossible;
  } lbm_caps_s;

  typedef struct packed {
    logic [LBM_RIS_W-1:0] resource_instance_selector;
    logic [LBM_MON_W-1:0] mon;
  } lbm_sel_s;

  typedef struct packed {
    logic        not_ready_bit;
    logic [62:0] value;
  } lbm_ctr_s;

endpackage

/* File: lbm_long_counter.sv */
// One long bandwidth counter: byte accumulation, software load and not-ready.
// Assumes the owner decodes writes and delivers pre-filtered byte events.
`timescale 1ns/10ps
module lbm_long_counter
  import lbm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   longWidth,
  input  wire logic                   wrEn,
  input  wire logic [63:0]            wrData,
  input  wire logic                   addEn,
  input  wire logic [LBM_BYTES_W-1:0] addBytes,
  input  wire logic                   setNotReady,
  output lbm_ctr_s                    state
);

  lbm_ctr_s st;
  lbm_ctr_s next_st;
  logic [63:0] sum;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    sum     = 64'h0;
    if (wrEn) begin
      next_st = wrData;
    end
    if (addEn) begin
      sum           = {1'b0, next_st.value} + {48'h0, addBytes}; // R11
      next_st.value = sum[62:0];
    end
    if (setNotReady) begin
      next_st.not_ready_bit = 1'b1; // R10
    end
    // The short form wraps at 44 bits so the upper bits stay zero.
    if (!longWidth) begin
      next_st = next_st & LBM_SHORT_MASK; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= LBM_RST_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign state = st;

endmodule // lbm_long_counter

/* File: lbm_regs_assertions.sv */
// Concurrent checks on the ports of the long bandwidth monitor register bank.
// Assumes it is bound to lbm_regs and sees nothing but that module's ports.
`timescale 1ns/10ps
module lbm_regs_assertions
  import lbm_pkg::*;
(
  input wire logic    clk,
  input wire logic    resetn,
  input lbm_caps_s    caps,
  input lbm_req_s     req,
  input lbm_rsp_s     rsp,
  input lbm_traffic_s traffic,
  input wire logic    captureValid,
  input wire logic    captureNonSecure,
  input wire logic    counterNotReady,
  input lbm_err_s     err,
  input wire logic    errIrqSecure,
  input wire logic    errIrqNonSecure
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic isRd(lbm_req_s r, logic [11:0] a);
    return r.valid && !r.write && r.addr == a;
  endfunction

  AST_READ_ANSWER: assert property (req.valid && !req.write |=> rsp.valid)
    else $error("read got no answer");
  AST_NO_EXTRA_ANSWER: assert property (!(req.valid && !req.write) |=> !rsp.valid)
    else $error("answer without read");
  AST_IDLE_ZERO: assert property (!rsp.valid |-> rsp.rdata == '0)
    else $error("read data not zero while idle");
  AST_CTRL_RES0: assert property (isRd(req, LBM_OFS_ERR_CTRL) |=> rsp.rdata[63:1] == '0)
    else $error("error control reserved bits set");
  AST_STATUS_RES0: assert property (isRd(req, LBM_OFS_ERR_STATUS) |=> rsp.rdata[63:36] == '0
    && rsp.rdata[30:28] == '0 && (caps.hasExtendedStatus || rsp.rdata[35:32] == '0))
    else $error("status reserved bits set");
  AST_SHORT_RES0: assert property ((isRd(req, LBM_OFS_LONG_SNAP) || isRd(req, LBM_OFS_LONG_CTR))
    && !caps.longWidth |=> rsp.rdata[62:44] == '0)
    else $error("short form upper bits set");
  AST_SNAP_ABSENT: assert property (isRd(req, LBM_OFS_LONG_SNAP) && !(caps.hasMonitoring
    && caps.hasBwMonitor && caps.hasCapture && caps.hasLong) |=> rsp.rdata == '0)
    else $error("absent snapshot not zero");
  AST_NOERR_RAZ: assert property (!caps.errorsPossible && (isRd(req, LBM_OFS_ERR_CTRL)
    || isRd(req, LBM_OFS_ERR_STATUS)) |=> rsp.rdata == '0 && !errIrqSecure && !errIrqNonSecure)
    else $error("error registers not zero");
  AST_IRQ_CAUSE: assert property ($changed(errIrqSecure) |-> ($past(req.valid) && !$past(req.nonSecure))
    || ($past(err.valid) && !$past(err.nonSecure)))
    else $error("secure irq moved without secure cause");

  cover property (isRd(req, LBM_OFS_LONG_SNAP) ##1 rsp.valid);
  cover property ($rose(errIrqSecure));
  cover property (captureValid && !captureNonSecure);
endmodule // lbm_regs_assertions

bind lbm_regs lbm_regs_assertions u_chk (.clk(clk), .resetn(resetn), .caps(caps), .req(req), .rsp(rsp),
  .traffic(traffic), .captureValid(captureValid), .captureNonSecure(captureNonSecure),
  .counterNotReady(counterNotReady), .err(err), .errIrqSecure(errIrqSecure), .errIrqNonSecure(errIrqNonSecure));

/* File: tb.sv */
// Self-checking bench for the long bandwidth monitor register bank.
// Assumes lbm_pkg and lbm_regs are compiled first; the checker binds itself.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb
  import lbm_pkg::*;
;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  lbm_caps_s    caps;
  lbm_req_s     req = '0;
  lbm_rsp_s     rsp;
  lbm_traffic_s traffic = '0;
  logic         captureValid = 1'b0;
  logic         captureNonSecure = 1'b0;
  logic         counterNotReady = 1'b0;
  lbm_err_s     err = '0;
  logic         errIrqSecure;
  logic         errIrqNonSecure;
  int           error_cnt = 0;
  int           tests_run = 0;
  logic [63:0]  expQ[$];
  logic [63:0]  expM;
  logic [62:0]  sumS;
  logic [62:0]  sumNs;
  logic [63:0]  snap;
  logic [15:0]  b;
  logic [27:0]  info;

  lbm_regs u_dut (.clk(clk), .resetn(resetn), .caps(caps), .req(req), .rsp(rsp), .traffic(traffic),
    .captureValid(captureValid), .captureNonSecure(captureNonSecure), .counterNotReady(counterNotReady),
    .err(err), .errIrqSecure(errIrqSecure), .errIrqNonSecure(errIrqNonSecure));

  always #2.5 clk = ~clk;

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // An idle cycle follows every strobe so no signal is assigned twice at once.
  task automatic acc(logic ns, logic wr, logic [11:0] a, logic [63:0] d);
    req = '{1'b1, ns, wr, a, d};
    step();
    req.valid = 1'b0;
    step();
  endtask
  task automatic rd(logic ns, logic [11:0] a, logic [63:0] e);
    expQ.push_back(e);
    acc(ns, 1'b0, a, '0);
  endtask
  task automatic tr(logic ns, logic [1:0] resource_instance_selector, logic [1:0] mon);
    b = 16'($urandom);
    traffic = '{1'b1, ns, resource_instance_selector, mon, b};
    step();
    traffic.valid = 1'b0;
    step();
  endtask
  task automatic cap(logic ns);
    captureNonSecure = ns;
    captureValid = 1'b1;
    step();
    captureValid = 1'b0;
    step();
  endtask
  task automatic er(logic ns, logic [3:0] code);
    info = 28'($urandom);
    err = {1'b1, ns, code, info};
    step();
    err.valid = 1'b0;
    step();
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Response watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (rsp.valid === 1'b1) begin
      expM = (expQ.size() > 0) ? expQ.pop_front() : 64'hx;
      `CHK("rdata", expM, rsp.rdata)
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'he0cd0dc6));
    caps = 8'hff;
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    rd(1'b0, LBM_OFS_ERR_CTRL, 64'h0);
    acc(1'b0, 1'b1, LBM_OFS_ERR_CTRL, 64'hffff_ffff_ffff_ffff);
    rd(1'b0, LBM_OFS_ERR_CTRL, 64'h1);
    rd(1'b1, LBM_OFS_ERR_CTRL, 64'h0);
    acc(1'b0, 1'b1, LBM_OFS_MON_SELECT, 64'h0200_0001);
    acc(1'b1, 1'b1, LBM_OFS_MON_SELECT, 64'h0200_0001);
    sumS = '0;
    sumNs = '0;
    for (int i = 0; i < 6; i++) begin
      tr(1'b0, 2'h2, 2'h1);
      sumS += 63'(b);
      tr(1'b1, 2'h2, 2'h1);
      sumNs += 63'(b);
      tr(1'b0, 2'h1, 2'h1);
      tr(1'b0, 2'h2, 2'h2);
    end
    rd(1'b0, LBM_OFS_LONG_CTR, {1'b0, sumS});
    rd(1'b1, LBM_OFS_LONG_CTR, {1'b0, sumNs});
    cap(1'b0);
    snap = {1'b0, sumS};
    tr(1'b0, 2'h2, 2'h1);
    sumS += 63'(b);
    rd(1'b0, LBM_OFS_LONG_SNAP, snap);
    rd(1'b1, LBM_OFS_LONG_SNAP, 64'h0);
    rd(1'b0, LBM_OFS_LONG_CTR, {1'b0, sumS});
    counterNotReady = 1'b1;
    step();
    counterNotReady = 1'b0;
    cap(1'b0);
    rd(1'b0, LBM_OFS_LONG_SNAP, {1'b1, sumS});
    acc(1'b0, 1'b1, LBM_OFS_LONG_CTR, 64'h4000_0000_0000_0000);
    tr(1'b0, 2'h2, 2'h1);
    rd(1'b0, LBM_OFS_LONG_CTR, 64'h4000_0000_0000_0000 + 64'(b));
    er(1'b0, 4'h5);
    `CHK("irqSecure", 1'b1, errIrqSecure)
    `CHK("irqNonSecure", 1'b0, errIrqNonSecure)
    rd(1'b0, LBM_OFS_ERR_STATUS, {28'h0, info[27:24], 4'h0, 4'h5, info[23:0]});
    er(1'b0, 4'h3);
    rd(1'b0, LBM_OFS_ERR_STATUS, {28'h0, info[27:24], 4'h8, 4'h3, info[23:0]});
    rd(1'b1, LBM_OFS_ERR_STATUS, 64'h0);
    acc(1'b0, 1'b1, LBM_OFS_ERR_STATUS, 64'h0);
    `CHK("irqSecure", 1'b0, errIrqSecure)
    er(1'b1, 4'h2);
    `CHK("irqNonSecure", 1'b0, errIrqNonSecure)
    rd(1'b1, LBM_OFS_ERR_STATUS, {28'h0, info[27:24], 4'h0, 4'h2, info[23:0]});
    acc(1'b1, 1'b1, LBM_OFS_ERR_CTRL, 64'h1);
    `CHK("irqNonSecure", 1'b1, errIrqNonSecure)
    `CHK("irqSecure", 1'b0, errIrqSecure)
    // Second configuration: short counters, no instance select, no capture, no errors.
    resetn = 1'b0;
    caps = 8'b1101_0000;
    repeat (20) step();
    resetn = 1'b1;
    acc(1'b0, 1'b1, LBM_OFS_MON_SELECT, 64'h0300_0002);
    rd(1'b0, LBM_OFS_MON_SELECT, 64'h2);
    acc(1'b0, 1'b1, LBM_OFS_LONG_CTR, 64'hffff_ffff_ffff_ffff);
    rd(1'b0, LBM_OFS_LONG_CTR, 64'h8000_0fff_ffff_ffff);
    tr(1'b0, 2'h0, 2'h2);
    rd(1'b0, LBM_OFS_LONG_CTR, {20'h80000, 44'(b) - 44'h1});
    acc(1'b0, 1'b1, LBM_OFS_LONG_SNAP, 64'hffff_ffff_ffff_ffff);
    rd(1'b0, LBM_OFS_LONG_SNAP, 64'h0);
    acc(1'b0, 1'b1, LBM_OFS_ERR_CTRL, 64'h1);
    rd(1'b0, LBM_OFS_ERR_CTRL, 64'h0);
    er(1'b0, 4'h1);
    `CHK("irqSecure", 1'b0, errIrqSecure)
    rd(1'b0, LBM_OFS_ERR_STATUS, 64'h0);
    rd(1'b0, 12'h100, 64'h0);
    // Third configuration: short counters, no instance select, narrow error status.
    resetn = 1'b0;
    caps = 8'b1111_0001;
    repeat (20) step();
    resetn = 1'b1;
    acc(1'b1, 1'b1, LBM_OFS_MON_SELECT, 64'h0300_0003);
    tr(1'b1, 2'h3, 2'h3);
    cap(1'b1);
    rd(1'b1, LBM_OFS_LONG_SNAP, {20'h0, 44'(b)});
    rd(1'b0, LBM_OFS_LONG_SNAP, 64'h0);
    er(1'b0, 4'h4);
    `CHK("irqSecure", 1'b0, errIrqSecure)
    rd(1'b0, LBM_OFS_ERR_STATUS, {32'h0, 4'h0, 4'h4, info[23:0]});
    for (int i = 0; i < 4 && expQ.size() > 0; i++) begin
      step();
    end
    if (expQ.size() > 0) begin
      error_cnt++;
    end
    end_of_test();
  end
endmodule // tb
